// File: rtl/sdps_pkg.sv
// Package for the DDR4 power-state and DLL-off qualification block
// Assumes a single 100 MHz clock domain; controller pins are synchronised inside the block
package sdps_pkg;

  // ****************************************
  // Command pin bundle and decoded commands
  // ****************************************
  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdps_cmd_pins_t;

  typedef enum logic [2:0] {
    CMD_DESELECT,
    CMD_NO_OPERATION,
    CMD_REFRESH,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_OTHER
  } sdps_cmd_t;

  typedef enum {
    ST_IDLE,
    ST_ACTIVE,
    ST_PRECHARGE_PD,
    ST_ACTIVE_PD,
    ST_SELF_REFRESH
  } sdps_state_t;

  // ****************************************
  // Latencies and reset values
  // ****************************************
  localparam logic [4:0] DLL_OFF_READ_LATENCY  = 5'h0_00A;
  localparam logic [4:0] DLL_OFF_WRITE_LATENCY = 5'h0_009;
  localparam logic [5:0] STROBE_CNT_RESET      = 6'h0_000;
  localparam logic       DLL_ENABLE_RESET      = 1'h0_001;

  // Status flags handed out of the block
  typedef struct packed {
    logic power_down;
    logic active_pd;
    logic self_refresh;
    logic idle;
    logic illegal;
    logic dll_off;
  } sdps_status_t;

endpackage : sdps_pkg

// File: rtl/sdps_power_state.sv
// Power-state, command qualification and DLL-off read strobe timing
// Assumes controller pins are asynchronous to CLK and are synchronised here
//
// How it works
// - Power-down entry and exit only accepted with deselect on that edge.
// - Self refresh entered from idle with refresh on clock enable fall.
// - Deselect on clock enable fall picks precharge or active power-down.
// - No internal refresh while in power-down.
// - Self-refresh exit only with deselect; other commands flagged illegal.
// - Combinations not listed are flagged illegal.
// - Termination input ignored for state; termination off in self refresh.
// - Idle needs banks closed, no burst, enable high, timings expired.
// - Chip select high: no new command, running work continues.
// - DLL off when enable bit cleared, until set again.
// - DLL-off mode uses read latency 10 and write latency 9.
// - DLL-off strobe starts additive plus read latency minus one.
// - Commands decoded from pins and clock enable on rising edge.
`timescale 1ns/100ps
`default_nettype none

module sdps_power_state
  import sdps_pkg::*;
#(
  parameter int LAT_W = 6
)
(
  // Clock and reset
  input  wire logic           CLK,
  input  wire logic           NRST,
  // Controller pins
  input  wire sdps_cmd_pins_t CMD_PINS,
  input  wire logic           CKE,
  input  wire logic           TERM_CTRL,
  // Core status inputs, same clock
  input  wire logic           BANKS_CLOSED,
  input  wire logic           BURST_ACTIVE,
  input  wire logic           TIMINGS_DONE,
  // Mode settings, same clock
  input  wire logic           MODE_WRITE,
  input  wire logic           DLL_ENABLE_BIT,
  input  wire logic [4:0]     ADDITIVE_LATENCY,
  input  wire logic [4:0]     READ_LATENCY,
  // Outputs
  output sdps_status_t        STATUS,
  output logic                ACCEPT_CMD,
  output logic                REFRESH_ALLOWED,
  output logic                TERM_ENABLE,
  output logic                STROBE_START
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    sdps_cmd_pins_t pins_s1;
    sdps_cmd_pins_t pins_s2;
    logic           cke_s1;
    logic           cke_s2;
    logic           term_s1;
    logic           term_s2;
    logic           cke_prev;
    sdps_state_t    state;
    logic           dll_en;
    logic [LAT_W-1:0] strobe_cnt;
    sdps_status_t   status;
    logic           accept;
    logic           term_en;
    logic           strobe;
  } sdps_regs_t;

  sdps_regs_t r;
  sdps_regs_t next_r;
  sdps_cmd_t  cmd;
  logic       idle;
  logic [LAT_W-1:0] strobe_delay;

  // Decode from synchronised pins; row commands fold into other
  always_comb
  begin
    if (r.pins_s2.cs_n)
      cmd = CMD_DESELECT;
    else if (!r.pins_s2.act_n)
      cmd = CMD_OTHER;
    else
    begin
      case ({r.pins_s2.ras_n, r.pins_s2.cas_n, r.pins_s2.we_n})
        3'b111:  cmd = CMD_NO_OPERATION;
        3'b001:  cmd = CMD_REFRESH;
        3'b101:  cmd = CMD_READ;
        3'b100:  cmd = CMD_WRITE;
        3'b010:  cmd = CMD_PRECHARGE;
        default: cmd = CMD_OTHER;
      endcase
    end
  end

  // Idle qualification, the termination pin plays no part
  assign idle = BANKS_CLOSED && !BURST_ACTIVE && r.cke_s2 && TIMINGS_DONE;

  // Strobe window starts one clock early with the DLL off
  assign strobe_delay = LAT_W'(ADDITIVE_LATENCY) + LAT_W'(READ_LATENCY)
                        - (r.dll_en ? LAT_W'(0) : LAT_W'(1));

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_r          = r;
    next_r.pins_s1  = CMD_PINS;
    next_r.pins_s2  = r.pins_s1;
    next_r.cke_s1   = CKE;
    next_r.cke_s2   = r.cke_s1;
    next_r.term_s1  = TERM_CTRL;
    next_r.term_s2  = r.term_s1;
    next_r.cke_prev = r.cke_s2;
    next_r.status.illegal = 1'b0;
    next_r.strobe   = 1'b0;
    // Enable bit taken whenever the mode is written, in any state
    if (MODE_WRITE)
      next_r.dll_en = DLL_ENABLE_BIT;
    case (r.state)
      ST_PRECHARGE_PD, ST_ACTIVE_PD, ST_SELF_REFRESH:
      begin
        if (r.cke_prev && r.cke_s2)
          next_r.status.illegal = 1'b1;
        else if (!r.cke_prev && r.cke_s2)
        begin
          if (cmd == CMD_DESELECT)
            next_r.state = (r.state == ST_ACTIVE_PD) ? ST_ACTIVE : ST_IDLE;
          else
            next_r.status.illegal = 1'b1;
        end
      end
      ST_IDLE, ST_ACTIVE:
      begin
        if (r.cke_prev && !r.cke_s2)
        begin
          if (cmd == CMD_DESELECT)
            next_r.state = BANKS_CLOSED ? ST_PRECHARGE_PD : ST_ACTIVE_PD;
          // Idle is judged as it stood before this edge; clock enable is already low on it
          else if (cmd == CMD_REFRESH && r.state == ST_IDLE && BANKS_CLOSED && !BURST_ACTIVE && TIMINGS_DONE)
            next_r.state = ST_SELF_REFRESH;
          else
            next_r.status.illegal = 1'b1;
        end
        else if (!r.cke_prev)
          next_r.status.illegal = 1'b1;
        else
          next_r.state = (BANKS_CLOSED && !BURST_ACTIVE) ? ST_IDLE : ST_ACTIVE;
      end
      default: next_r.state = ST_IDLE;
    endcase
    // Commands taken only in the awake states with chip select low
    next_r.accept = (r.state == ST_IDLE || r.state == ST_ACTIVE) && cmd != CMD_DESELECT
                    && r.cke_s2;
    // Read strobe countdown, a new read restarts it
    if (next_r.accept && cmd == CMD_READ)
      next_r.strobe_cnt = strobe_delay;
    else if (r.strobe_cnt != STROBE_CNT_RESET)
    begin
      next_r.strobe_cnt = r.strobe_cnt - LAT_W'(1);
      next_r.strobe     = (r.strobe_cnt == LAT_W'(1));
    end
    next_r.term_en = r.term_s2 && (next_r.state != ST_SELF_REFRESH);
    next_r.status.power_down   = next_r.state == ST_PRECHARGE_PD || next_r.state == ST_ACTIVE_PD;
    next_r.status.active_pd    = next_r.state == ST_ACTIVE_PD;
    next_r.status.self_refresh = next_r.state == ST_SELF_REFRESH;
    next_r.status.idle         = next_r.state == ST_IDLE && idle;
    next_r.status.dll_off      = !next_r.dll_en;
  end

  // Register everything; pins reset to deselect with enable low
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      r            <= '0;
      r.pins_s1    <= '1;
      r.pins_s2    <= '1;
      r.state      <= ST_IDLE;
      r.dll_en     <= DLL_ENABLE_RESET;
    end
    else
      r <= next_r;
  end

  assign STATUS          = r.status;
  assign ACCEPT_CMD      = r.accept;
  assign TERM_ENABLE     = r.term_en;
  assign STROBE_START    = r.strobe;
  // Internal refresh held off in power-down
  assign REFRESH_ALLOWED = !r.status.power_down;

  // ****************************************
  // Assertions
  // ****************************************
  AST_PD_EXIT: assert property (@(posedge CLK) disable iff (!NRST)
    (r.state == ST_PRECHARGE_PD && !r.cke_prev && r.cke_s2 && cmd == CMD_DESELECT)
      |=> r.state == ST_IDLE) else $error("Power-down exit missed");
  AST_PD_HOLD: assert property (@(posedge CLK) disable iff (!NRST)
    (r.status.power_down && !r.cke_prev && !r.cke_s2) |=> $stable(r.state))
    else $error("Power-down not held");
  AST_SR_ENTRY: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(r.status.self_refresh) |-> $past(r.state) == ST_IDLE)
    else $error("Self refresh from non-idle");
  AST_PD_TYPE: assert property (@(posedge CLK) disable iff (!NRST)
    (r.state == ST_ACTIVE && r.cke_prev && !r.cke_s2 && cmd == CMD_DESELECT && !BANKS_CLOSED)
      |=> r.state == ST_ACTIVE_PD ##1 r.status.active_pd) else $error("Wrong power-down type");
  AST_NO_REFRESH: assert property (@(posedge CLK) disable iff (!NRST)
    r.status.power_down |-> !REFRESH_ALLOWED) else $error("Refresh in power-down");
  AST_SR_BADEXIT: assert property (@(posedge CLK) disable iff (!NRST)
    (r.state == ST_SELF_REFRESH && !r.cke_prev && r.cke_s2 && cmd != CMD_DESELECT)
      |=> r.status.illegal && r.state == ST_SELF_REFRESH) else $error("Bad exit not flagged");
  AST_TERM_OFF: assert property (@(posedge CLK) disable iff (!NRST)
    r.status.self_refresh |-> !TERM_ENABLE) else $error("Termination in self refresh");
  AST_DESELECT: assert property (@(posedge CLK) disable iff (!NRST)
    cmd == CMD_DESELECT |=> !ACCEPT_CMD) else $error("Command taken while deselected");
  AST_STROBE: assert property (@(posedge CLK) disable iff (!NRST)
    (ACCEPT_CMD && $past(cmd) == CMD_READ && !r.dll_en && r.strobe_cnt == LAT_W'(9))
      |-> ##9 STROBE_START) else $error("Strobe timing wrong");
  AST_DLL: assert property (@(posedge CLK) disable iff (!NRST)
    (MODE_WRITE && !DLL_ENABLE_BIT) |=> r.status.dll_off) else $error("DLL not off");

  COV_SR:  cover property (@(posedge CLK) disable iff (!NRST) $fell(r.status.self_refresh));
  COV_PPD: cover property (@(posedge CLK) disable iff (!NRST) r.state == ST_PRECHARGE_PD);
  COV_APD: cover property (@(posedge CLK) disable iff (!NRST) $fell(r.status.active_pd));
  COV_STB: cover property (@(posedge CLK) disable iff (!NRST) STROBE_START && STATUS.dll_off);

endmodule : sdps_power_state

`default_nettype wire

// File: sim/sdps_ctrl_model.sv
// Controller-side pin model for the power-state block
// Assumes the bench posts one request per clock on the rising edge
`timescale 1ns/100ps
`default_nettype none
module sdps_ctrl_model
  import sdps_pkg::*;
(
  // Clock
  input  wire logic           CLK,
  // Bench requests
  input  wire sdps_cmd_t      REQ_CMD,
  input  wire logic           REQ_CKE,
  input  wire logic           REQ_TERM,
  // Device pins
  output var  sdps_cmd_pins_t CMD_PINS,
  output var  logic           CKE,
  output var  logic           TERM_CTRL
);
  logic [3:0] junk = 4'h0_005;
  // Deselect with clock enable low until the first clock edge
  initial {CMD_PINS, CKE, TERM_CTRL} = 7'h0_07C;
  // Pins move just after the edge; deselected pins churn since the device must ignore them
  always @(posedge CLK)
  begin
    junk      <= junk + 4'h0_007;
    CKE       <= REQ_CKE;
    TERM_CTRL <= REQ_TERM;
    case (REQ_CMD)
      CMD_NO_OPERATION: CMD_PINS <= 5'h0_00F;
      CMD_REFRESH:      CMD_PINS <= 5'h0_009;
      CMD_READ:         CMD_PINS <= 5'h0_00D;
      CMD_WRITE:        CMD_PINS <= 5'h0_00C;
      CMD_PRECHARGE:    CMD_PINS <= 5'h0_00A;
      default:          CMD_PINS <= {1'b1, junk};
    endcase
  end
endmodule : sdps_ctrl_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the power-state block
// Assumes the controller pin model; all reads run in DLL-off mode
`timescale 1ns/100ps
`default_nettype none
module testbench
  import sdps_pkg::*;
;
  logic           clk = 1'b0;
  logic           nrst = 1'b0;
  sdps_cmd_t      req_cmd = CMD_DESELECT;
  logic           req_cke = 1'b1;
  logic           req_term = 1'b0;
  logic           banks_closed = 1'b1;
  logic           burst_active = 1'b0;
  logic           timings_done = 1'b1;
  logic           mode_write = 1'b0;
  logic           dll_bit = 1'b1;
  logic [4:0]     al = 5'h0_000;
  logic [4:0]     rl = DLL_OFF_READ_LATENCY;
  sdps_cmd_pins_t pins;
  sdps_status_t   status;
  logic           cke, term, accept_cmd, refresh_allowed, term_enable, strobe_start;
  logic [4:0]     p1, p2;
  logic           k1, k2, kp, e_ill, e_acc, e_stb, loose;
  int             ms, due, cyc, mismatches = 0, checks = 0;
  sdps_cmd_t      cmds[3] = '{CMD_WRITE, CMD_PRECHARGE, CMD_REFRESH};

  // 100 MHz, well inside the slow-clock limit of DLL-off mode
  always #5 clk = ~clk;

  sdps_ctrl_model i_ctrl (.CLK(clk), .REQ_CMD(req_cmd), .REQ_CKE(req_cke), .REQ_TERM(req_term),
    .CMD_PINS(pins), .CKE(cke), .TERM_CTRL(term));
  sdps_power_state i_dut (.CLK(clk), .NRST(nrst), .CMD_PINS(pins), .CKE(cke), .TERM_CTRL(term),
    .BANKS_CLOSED(banks_closed), .BURST_ACTIVE(burst_active), .TIMINGS_DONE(timings_done),
    .MODE_WRITE(mode_write), .DLL_ENABLE_BIT(dll_bit), .ADDITIVE_LATENCY(al), .READ_LATENCY(rl),
    .STATUS(status), .ACCEPT_CMD(accept_cmd), .REFRESH_ALLOWED(refresh_allowed),
    .TERM_ENABLE(term_enable), .STROBE_START(strobe_start));

  // ****
  // Helpers
  // ****
  task automatic chk(input logic seen, input logic exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // One command edge, then deselects with the same clock enable for n cycles
  task automatic go(input sdps_cmd_t c, input logic k, input int n);
    req_cmd <= c;
    req_cke <= k;
    @(posedge clk);
    req_cmd <= CMD_DESELECT;
    repeat (n) @(posedge clk);
  endtask : go

  // Level outputs once the pins have been still for a while
  task automatic settle();
    chk(status.idle, ms == 0 && banks_closed && !burst_active && timings_done);
    chk(status.dll_off, !dll_bit);
    chk(term_enable, req_term && ms != 4);
  endtask : settle

  // Reference model: two sync stages, then state and pulses per clock-enable history
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {ms, due, cyc, p1, p2, k1, k2, kp} = {32'd0, -32'sd1, 32'd0, 5'h0_01F, 5'h0_01F, 3'h0_000};
    end
    else
    begin
      cyc++;
      {e_ill, e_acc} = 2'h0_000;
      e_stb = (cyc == due);
      loose = (ms == 0 && !kp);
      if (ms != 0 && !kp && k2)
      begin
        if (p2[4]) ms = 0;
        else e_ill = 1'b1;
      end
      else if (ms != 0 && kp && k2) e_ill = 1'b1;
      else if (ms == 0 && kp && !k2)
      begin
        if (p2[4]) ms = banks_closed ? 2 : 3;
        else if (p2 == 5'h0_009 && banks_closed && !burst_active && timings_done) ms = 4;
        else e_ill = 1'b1;
      end
      else if (ms == 0 && kp && k2 && !p2[4])
      begin
        e_acc = 1'b1;
        if (p2 == 5'h0_00D) due = cyc + al + rl - 1;
      end
      {kp, k2, k1, p2, p1} = {k2, k1, cke, p1, pins};
    end
  end

  // Compare pulses and power flags every cycle, clear of the edge
  always @(negedge clk)
  begin
    if (nrst && cyc > 6)
    begin
      chk(status.power_down, ms == 2 || ms == 3);
      chk(status.active_pd, ms == 3);
      chk(status.self_refresh, ms == 4);
      chk(refresh_allowed, !(ms == 2 || ms == 3));
      chk(accept_cmd, e_acc);
      chk(strobe_start, e_stb);
      if (!loose) chk(status.illegal, e_ill);
    end
  end

  // ****
  // Main sequence
  // ****
  initial
  begin
    void'($urandom(32'h0000_dd04));
    repeat (10) @(posedge clk);
    chk(refresh_allowed, 1'b1);
    chk(status.dll_off, 1'b0);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    dll_bit    <= 1'b0;
    mode_write <= 1'b1;
    @(posedge clk);
    mode_write <= 1'b0;
    go(CMD_DESELECT, 1'b1, 6);
    settle();
    for (int i = 0; i < 4; i++)
    begin
      banks_closed <= i[0];
      go(CMD_DESELECT, 1'b0, 6);
      settle();
      go(CMD_DESELECT, 1'b1, 6);
      settle();
    end
    banks_closed <= 1'b1;
    burst_active <= 1'b1;
    go(CMD_REFRESH, 1'b0, 4);
    go(CMD_DESELECT, 1'b1, 6);
    burst_active <= 1'b0;
    go(CMD_READ, 1'b0, 4);
    go(CMD_DESELECT, 1'b1, 6);
    settle();
    req_term <= 1'b1;
    go(CMD_DESELECT, 1'b1, 6);
    go(CMD_REFRESH, 1'b0, 8);
    settle();
    // Wake attempt with a command is refused; drop clock enable again before the clean exit
    go(CMD_WRITE, 1'b1, 3);
    go(CMD_DESELECT, 1'b0, 6);
    req_term <= 1'b0;
    go(CMD_DESELECT, 1'b1, 10);
    settle();
    for (int i = 0; i < 6; i++)
    begin
      al       <= (i == 0) ? 5'h0_000 : 5'($urandom_range(4));
      req_term <= 1'($urandom_range(1));
      go(CMD_READ, 1'b1, 20);
    end
    foreach (cmds[i]) go(cmds[i], 1'b1, 3);
    timings_done <= 1'b0;
    go(CMD_DESELECT, 1'b1, 4);
    settle();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
